//--- osc_ctrl_pkg.sv
// Shared constants for the dual oscillator clock select block
package osc_ctrl_pkg;

  // Bus map: byte offsets within the block's window
  localparam logic [15:0] CTRL_OFFSET   = 16'hff00;
  localparam logic [15:0] STATUS_OFFSET = 16'hff04;

  // Control word fields
  localparam int unsigned CPU_CLOCK_SELECT_BIT       = 3;
  localparam int unsigned FAST_OSCILLATOR_ENABLE_BIT = 2;
  localparam int unsigned CORE_VOLTAGE_SELECT_BIT    = 0;
  localparam logic [3:0]  CTRL_WRITE_MASK            = 4'hd;
  localparam logic [3:0]  CTRL_RESET                 = 4'h0;

  // Status word fields
  localparam int unsigned STAT_CPU_ON_HIGH_BIT   = 0;
  localparam int unsigned STAT_HIGH_SETTLED_BIT  = 1;
  localparam int unsigned STAT_SUPPLY_HIGH_BIT   = 2;
  localparam int unsigned STAT_SWITCH_BUSY_BIT   = 3;

  // AHB-Lite encodings
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0]  HSIZE_WORD    = 3'h2;

  // Clock rates in hertz
  localparam int unsigned CLK_HZ          = 250000000;
  localparam int unsigned LOW_CRYSTAL_HZ  = 32768;
  localparam int unsigned LOW_CR_HZ       = 60000;
  localparam int unsigned HIGH_HZ         = 4000000;

  // Fast oscillator settling time, microseconds
  localparam int unsigned HIGH_SETTLE_US  = 5000;
  localparam int unsigned CLK_PER_US      = CLK_HZ / 1000000;

  // System clock periods per instruction cycle
  localparam int unsigned PERIODS_PER_CYCLE = 2;

  typedef enum logic [1:0] {
    SRC_LOW,
    SRC_TO_HIGH,
    SRC_HIGH,
    SRC_TO_LOW
  } clk_src_state_t;

endpackage

//--- rate_enable.sv
// Fractional rate divider giving one-cycle enable pulses
`timescale 1ns/100ps
module rate_enable #(
  parameter int unsigned CLK_HZ = 250000000,
  parameter int unsigned OUT_HZ = 32768,
  parameter int unsigned ACC_W  = 32
) (
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  input  wire logic run_i,
  input  wire logic restart_i,
  output logic      tick_o
);

  localparam logic [ACC_W:0] INC = (ACC_W+1)'(OUT_HZ);
  localparam logic [ACC_W:0] MOD = (ACC_W+1)'(CLK_HZ);

  logic [ACC_W-1:0] acc_r;
  logic [ACC_W:0]   sum;
  logic             wrap;
  logic [ACC_W-1:0] acc_nxt;

  // Average rate is exact; phase restarts so a first period is whole
  assign sum     = {1'b0, acc_r} + INC;
  assign wrap    = (sum >= MOD);
  assign acc_nxt = wrap ? ACC_W'(sum - MOD) : ACC_W'(sum);

  always_ff @(posedge clk_i) begin
    if (!reset_n_i || !run_i || restart_i) begin
      acc_r  <= '0;
      tick_o <= 1'b0;
    end else begin
      acc_r  <= acc_nxt;
      tick_o <= wrap;
    end
  end

endmodule // rate_enable

//--- osc_clock_select.sv
// Dual oscillator clock select with AHB-Lite control registers
//
// Our own choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/100ps
module osc_clock_select #(
  parameter bit          LOW_OSC_IS_CR  = 1'b0,
  parameter int unsigned CLK_HZ         = osc_ctrl_pkg::CLK_HZ,
  parameter int unsigned LOW_CRYSTAL_HZ = osc_ctrl_pkg::LOW_CRYSTAL_HZ,
  parameter int unsigned LOW_CR_HZ      = osc_ctrl_pkg::LOW_CR_HZ,
  parameter int unsigned HIGH_HZ        = osc_ctrl_pkg::HIGH_HZ,
  parameter int unsigned HIGH_SETTLE_CYC =
    osc_ctrl_pkg::HIGH_SETTLE_US * osc_ctrl_pkg::CLK_PER_US
) (
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  // AHB-Lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic [31:0]      hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // Clock enables
  output logic             low_clk_en_o,
  output logic             high_clk_en_o,
  output logic             sys_clk_en_o,
  output logic             instr_cycle_en_o,
  // Analog controls and state
  output logic             fast_oscillator_enable_o,
  output logic             internal_core_supply_high_o,
  output logic             cpu_on_high_o
);

  localparam int unsigned LOW_HZ = LOW_OSC_IS_CR ? LOW_CR_HZ : LOW_CRYSTAL_HZ;
  localparam logic [31:0] SETTLE_CYC = 32'(HIGH_SETTLE_CYC);

  // Control word
  logic [3:0]  ctrl_r;
  logic [3:0]  ctrl_nxt;
  logic [3:0]  ctrl_wr;
  // Bus address phase capture
  logic        wr_pend_r;
  logic [15:0] wr_addr_r;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  // Clock switching
  osc_ctrl_pkg::clk_src_state_t src_r;
  osc_ctrl_pkg::clk_src_state_t src_nxt;
  logic        low_tick;
  logic        high_tick;
  logic        low_restart;
  logic        high_restart;
  logic        sys_tick;
  logic        half_r;
  logic [31:0] settle_cnt_r;
  logic        settled_r;
  logic        supply_high_r;
  logic        sys_en_r;
  logic        instr_en_r;

  wire logic addr_phase = hsel_i && hready_i && htrans_i[1];
  wire logic rd_phase   = addr_phase && !hwrite_i;
  wire logic wr_phase   = addr_phase && hwrite_i;
  wire logic wr_do      = wr_pend_r && hready_i;
  wire logic wr_ctrl    = wr_do && (wr_addr_r == osc_ctrl_pkg::CTRL_OFFSET);

  wire logic sel_bit  = ctrl_r[osc_ctrl_pkg::CPU_CLOCK_SELECT_BIT];
  wire logic fast_oscillator_enable_bit = ctrl_r[osc_ctrl_pkg::FAST_OSCILLATOR_ENABLE_BIT];
  wire logic vdc_bit  = ctrl_r[osc_ctrl_pkg::CORE_VOLTAGE_SELECT_BIT];

  // Fast source is only usable while its oscillator runs
  wire logic want_high = sel_bit && fast_oscillator_enable_bit;

  function automatic logic [31:0] read_word(
    input logic [15:0] addr,
    input logic [3:0]  ctrl,
    input logic [3:0]  status
  );
    logic [31:0] w;
    w = 32'h0000_0000;
    if (addr == osc_ctrl_pkg::CTRL_OFFSET) begin
      w[3:0] = ctrl & osc_ctrl_pkg::CTRL_WRITE_MASK;
    end else if (addr == osc_ctrl_pkg::STATUS_OFFSET) begin
      w[3:0] = status;
    end
    return w;
  endfunction

  // Write filter: fast select refused at low supply with oscillator off
  always_comb begin
    ctrl_wr = hwdata_i[3:0] & osc_ctrl_pkg::CTRL_WRITE_MASK;
    if (!ctrl_wr[osc_ctrl_pkg::CORE_VOLTAGE_SELECT_BIT] &&
        !ctrl_wr[osc_ctrl_pkg::FAST_OSCILLATOR_ENABLE_BIT]) begin
      ctrl_wr[osc_ctrl_pkg::CPU_CLOCK_SELECT_BIT] = 1'b0;
    end
  end

  assign ctrl_nxt = wr_ctrl ? ctrl_wr : ctrl_r;

  wire logic [3:0] status_now = {
    (src_r == osc_ctrl_pkg::SRC_TO_HIGH) || (src_r == osc_ctrl_pkg::SRC_TO_LOW),
    supply_high_r,
    settled_r,
    (src_r == osc_ctrl_pkg::SRC_HIGH) || (src_r == osc_ctrl_pkg::SRC_TO_LOW)
  };

  // Reads see a write finishing in the same cycle
  assign rdata_nxt = rd_phase ? read_word(haddr_i[15:0], ctrl_nxt, status_now)
                              : rdata_r;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      ctrl_r    <= osc_ctrl_pkg::CTRL_RESET;
      wr_pend_r <= 1'b0;
      wr_addr_r <= 16'h0000;
      rdata_r   <= 32'h0000_0000;
    end else begin
      ctrl_r  <= ctrl_nxt;
      rdata_r <= rdata_nxt;
      if (hready_i) begin
        wr_pend_r <= wr_phase;
        wr_addr_r <= haddr_i[15:0];
      end
    end
  end

  // Low-speed source: always running
  rate_enable #(
    .CLK_HZ (CLK_HZ),
    .OUT_HZ (LOW_HZ),
    .ACC_W  (32)
  ) u_low_osc (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .run_i     (1'b1),
    .restart_i (low_restart),
    .tick_o    (low_tick)
  );

  // Fast source: runs only while enabled
  rate_enable #(
    .CLK_HZ (CLK_HZ),
    .OUT_HZ (HIGH_HZ),
    .ACC_W  (32)
  ) u_high_osc (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .run_i     (fast_oscillator_enable_bit),
    .restart_i (high_restart),
    .tick_o    (high_tick)
  );

  // Source switching waits for the old source's period edge, unless the fast oscillator has stopped
  always_comb begin
    src_nxt      = src_r;
    low_restart  = 1'b0;
    high_restart = 1'b0;
    case (src_r)
      osc_ctrl_pkg::SRC_LOW: begin
        if (want_high) begin
          src_nxt = osc_ctrl_pkg::SRC_TO_HIGH;
        end
      end
      osc_ctrl_pkg::SRC_TO_HIGH: begin
        if (!want_high) begin
          src_nxt = osc_ctrl_pkg::SRC_LOW;
        end else if (low_tick) begin
          src_nxt      = osc_ctrl_pkg::SRC_HIGH;
          high_restart = 1'b1;
        end
      end
      osc_ctrl_pkg::SRC_HIGH: begin
        if (!want_high) begin
          src_nxt = osc_ctrl_pkg::SRC_TO_LOW;
        end
      end
      osc_ctrl_pkg::SRC_TO_LOW: begin
        if (want_high) begin
          src_nxt = osc_ctrl_pkg::SRC_HIGH;
        end else if (high_tick || !fast_oscillator_enable_bit) begin
          // Fast period edge or fast source gone: fall back with a whole low period
          src_nxt     = osc_ctrl_pkg::SRC_LOW;
          low_restart = 1'b1;
        end
      end
      default: begin
        src_nxt = osc_ctrl_pkg::SRC_LOW;
      end
    endcase
  end

  // System clock enable taken from the active source
  assign sys_tick = ((src_r == osc_ctrl_pkg::SRC_LOW) ||
                     (src_r == osc_ctrl_pkg::SRC_TO_HIGH)) ? low_tick
                                                           : high_tick;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      src_r      <= osc_ctrl_pkg::SRC_LOW;
      half_r     <= 1'b0;
      sys_en_r   <= 1'b0;
      instr_en_r <= 1'b0;
    end else begin
      src_r      <= src_nxt;
      sys_en_r   <= sys_tick;
      instr_en_r <= sys_tick && half_r;
      if (sys_tick) begin
        half_r <= !half_r;
      end
    end
  end

  // Settling indicator for the fast oscillator
  always_ff @(posedge clk_i) begin
    if (!reset_n_i || !fast_oscillator_enable_bit) begin
      settle_cnt_r <= 32'h0000_0000;
      settled_r    <= 1'b0;
    end else if (settle_cnt_r >= SETTLE_CYC - 32'h0000_0001) begin
      settled_r <= 1'b1;
    end else begin
      settle_cnt_r <= settle_cnt_r + 32'h0000_0001;
    end
  end

  // Core supply level: fixed high for the CR option
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      supply_high_r <= LOW_OSC_IS_CR;
    end else begin
      supply_high_r <= LOW_OSC_IS_CR ? 1'b1 : vdc_bit;
    end
  end

  assign hrdata_o                    = rdata_r;
  assign hreadyout_o                 = 1'b1;
  assign hresp_o                     = 1'b0;
  assign low_clk_en_o                = low_tick;
  assign high_clk_en_o               = high_tick;
  assign sys_clk_en_o                = sys_en_r;
  assign instr_cycle_en_o            = instr_en_r;
  assign fast_oscillator_enable_o    = fast_oscillator_enable_bit;
  assign internal_core_supply_high_o = supply_high_r;
  assign cpu_on_high_o               = status_now[osc_ctrl_pkg::STAT_CPU_ON_HIGH_BIT];

endmodule // osc_clock_select

//--- osc_clock_select_chk.sv
// Port checker for the dual oscillator clock select block
`timescale 1ns/100ps
module osc_clock_select_chk #(
  parameter bit LOW_OSC_IS_CR = 1'b0
) (
  input wire logic        clk_i,
  input wire logic        reset_n_i,
  input wire logic        hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic        hready_i,
  input wire logic        hreadyout_o,
  input wire logic        hresp_o,
  input wire logic        low_clk_en_o,
  input wire logic        high_clk_en_o,
  input wire logic        sys_clk_en_o,
  input wire logic        instr_cycle_en_o,
  input wire logic        fast_oscillator_enable_o,
  input wire logic        internal_core_supply_high_o,
  input wire logic        cpu_on_high_o
);
  logic       wr_r;
  logic [1:0] sc_r;
  logic       seen_r;
  wire        ctl_take = hsel_i & hready_i & htrans_i[1] & hwrite_i &
                         (haddr_i[15:0] == osc_ctrl_pkg::CTRL_OFFSET);
  // Control write data phase and sys pulses since last instruction pulse
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      wr_r   <= 1'b0;
      sc_r   <= 2'h0;
      seen_r <= 1'b0;
    end else begin
      wr_r <= ctl_take;
      if (instr_cycle_en_o) begin
        sc_r   <= 2'h0;
        seen_r <= 1'b1;
      end else if (sys_clk_en_o) begin
        sc_r <= sc_r + 2'h1;
      end
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_wr_settled;
    wr_r ##1 1'b1;
  endsequence
  a_bus_okay: assert property (
    hreadyout_o && !hresp_o) else $error("bus not ready or not okay");
  a_osc_follow: assert property (
    wr_r |=> fast_oscillator_enable_o == $past(hwdata_i[2])
  ) else $error("fast oscillator enable did not follow write");
  a_supply_follow: assert property (
    s_wr_settled |=> internal_core_supply_high_o == (LOW_OSC_IS_CR | $past(hwdata_i[0], 2))
  ) else $error("core supply level wrong after write");
  a_high_off: assert property (
    !fast_oscillator_enable_o && !$past(fast_oscillator_enable_o) |-> !high_clk_en_o
  ) else $error("fast pulse while oscillator off");
  a_sys_source: assert property (
    sys_clk_en_o |-> $past(low_clk_en_o) || $past(high_clk_en_o)
  ) else $error("system pulse without source pulse");
  a_instr_sys: assert property (
    instr_cycle_en_o |-> sys_clk_en_o) else $error("instruction pulse off system pulse");
  a_instr_alt: assert property (
    sys_clk_en_o && seen_r |-> instr_cycle_en_o == (sc_r == 2'h1)
  ) else $error("instruction pulse not every second system pulse");
  a_fall_back: assert property (
    $fell(fast_oscillator_enable_o) |-> ##[0:2] !cpu_on_high_o
  ) else $error("cpu stays on stopped fast oscillator");
endmodule // osc_clock_select_chk

bind osc_clock_select osc_clock_select_chk #(.LOW_OSC_IS_CR(LOW_OSC_IS_CR)) u_chk (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
  .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i), .hready_i(hready_i),
  .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .low_clk_en_o(low_clk_en_o),
  .high_clk_en_o(high_clk_en_o), .sys_clk_en_o(sys_clk_en_o),
  .instr_cycle_en_o(instr_cycle_en_o), .fast_oscillator_enable_o(fast_oscillator_enable_o),
  .internal_core_supply_high_o(internal_core_supply_high_o), .cpu_on_high_o(cpu_on_high_o));

//--- tb.sv
// Self-checking bench for the dual oscillator clock select block
`timescale 1ns/100ps
module tb;
  localparam logic [15:0] ctl_a = osc_ctrl_pkg::CTRL_OFFSET;
  localparam logic [15:0] sts_a = osc_ctrl_pkg::STATUS_OFFSET;
  logic clk_i, reset_n_i, hsel_i, hwrite_i;
  logic [31:0] haddr_i, hwdata_i, hrdata_o;
  logic [1:0]  htrans_i;
  logic [2:0]  hsize_i;
  wire  logic  hready_i;
  logic hreadyout_o, hresp_o, low_o, high_o, sys_o, instr_o, osc_en_o, supply_o, on_high_o;
  logic cr_supply_o;
  int   error_cnt, checks;
  assign hready_i = hreadyout_o;
  osc_clock_select #(.LOW_CRYSTAL_HZ(5000000), .HIGH_HZ(25000000), .HIGH_SETTLE_CYC(20)) u_dut (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
    .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .low_clk_en_o(low_o), .high_clk_en_o(high_o), .sys_clk_en_o(sys_o),
    .instr_cycle_en_o(instr_o), .fast_oscillator_enable_o(osc_en_o),
    .internal_core_supply_high_o(supply_o), .cpu_on_high_o(on_high_o));
  // CR build option on the same bus, only its supply level is watched
  osc_clock_select #(.LOW_OSC_IS_CR(1'b1), .LOW_CR_HZ(5000000), .HIGH_HZ(25000000),
    .HIGH_SETTLE_CYC(20)) u_dut_cr (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
    .hready_i(hready_i), .hrdata_o(), .hreadyout_o(), .hresp_o(),
    .low_clk_en_o(), .high_clk_en_o(), .sys_clk_en_o(),
    .instr_cycle_en_o(), .fast_oscillator_enable_o(),
    .internal_core_supply_high_o(cr_supply_o), .cpu_on_high_o());
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic c, input string m);
    checks++;
    if (c !== 1'b1) begin
      error_cnt++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge clk_i);
    while (hready_i !== 1'b1) begin
      n++;
      if (n > 20) begin
        chk(1'b0, "bus wait timed out");
        complete_run;
      end
      @(posedge clk_i);
    end
  endtask
  // One single word transfer, held until hready is seen
  task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d);
    hsel_i   <= 1'b1;
    htrans_i <= osc_ctrl_pkg::HTRANS_NONSEQ;
    hwrite_i <= w;
    haddr_i  <= {16'h0000, a};
    wait_rdy;
    hsel_i   <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= w ? d : 32'h0000_0000;
    wait_rdy;
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(hrdata_o === e, "read data");
  endtask
  function automatic logic pick(input int s);
    return s == 0 ? low_o : s == 1 ? high_o : s == 2 ? sys_o : instr_o;
  endfunction
  // Cycles between two successive pulses of the picked output
  task automatic gap(input int s, input int e);
    int n;
    for (int k = 0; k < 2; k++) begin
      n = 0;
      do begin
        @(posedge clk_i);
        n++;
      end while (pick(s) !== 1'b1 && n < 600);
    end
    chk(n == e, "pulse spacing");
    if (n >= 600) begin
      complete_run;
    end
  endtask
  task automatic wait_on(input logic v);
    int n;
    n = 0;
    while (on_high_o !== v && n < 300) begin
      @(posedge clk_i);
      n++;
    end
    chk(on_high_o === v, "cpu clock source");
    if (n >= 300) begin
      complete_run;
    end
  endtask
  task automatic t_regs;
    rd_chk(ctl_a, 32'h0);
    chk(supply_o === 1'b0 && osc_en_o === 1'b0, "reset levels");
    chk(cr_supply_o === 1'b1, "cr supply at reset");
    bus(1'b1, ctl_a, 32'h0000_0008);
    rd_chk(ctl_a, 32'h0);
    bus(1'b1, 16'h1230, 32'h0000_000f);
    rd_chk(16'h1230, 32'h0);
    bus(1'b1, ctl_a, 32'hffff_ffff);
    rd_chk(ctl_a, 32'h0000_000d);
    bus(1'b1, ctl_a, 32'h0000_0000);
    rd_chk(ctl_a, 32'h0);
    gap(0, 50);
    gap(3, 100);
    $display("register test done");
  endtask
  task automatic t_switch;
    bus(1'b1, ctl_a, 32'h0000_0001);
    repeat (2) @(posedge clk_i);
    chk(supply_o === 1'b1, "supply raised");
    repeat (10) @(posedge clk_i);
    bus(1'b1, ctl_a, 32'h0000_0005);
    gap(1, 10);
    gap(2, 50);
    repeat (25) @(posedge clk_i);
    rd_chk(sts_a, 32'h0000_0006);
    bus(1'b1, ctl_a, 32'h0000_000d);
    wait_on(1'b1);
    gap(2, 10);
    gap(3, 20);
    bus(1'b1, ctl_a, 32'h0000_0005);
    wait_on(1'b0);
    gap(2, 50);
    bus(1'b1, ctl_a, 32'h0000_0001);
    repeat (3) @(posedge clk_i);
    chk(osc_en_o === 1'b0 && high_o === 1'b0, "fast oscillator stopped");
    bus(1'b1, ctl_a, 32'h0000_0000);
    repeat (2) @(posedge clk_i);
    chk(supply_o === 1'b0, "supply lowered");
    chk(cr_supply_o === 1'b1, "cr supply stays high");
    $display("switch test done");
  endtask
  initial begin
    error_cnt = 0;
    checks    = 0;
    reset_n_i = 1'b0;
    hsel_i    = 1'b0;
    haddr_i   = 32'h0000_0000;
    htrans_i  = 2'h0;
    hwrite_i  = 1'b0;
    hsize_i   = osc_ctrl_pkg::HSIZE_WORD;
    hwdata_i  = 32'h0000_0000;
    repeat (3) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(posedge clk_i);
    t_regs;
    t_switch;
    complete_run;
  end
endmodule // tb
